/* File: exc_nest_pkg.sv */
// shared constants for the cpu exception and interrupt nesting unit
package exc_nest_pkg;
    // -------------------------------------------------------------
    // program status word bit positions
    // -------------------------------------------------------------
    localparam int PSW_W = 32;
    localparam int PSW_NP_BIT = 7;
    localparam int PSW_EP_BIT = 6;
    localparam int PSW_ID_BIT = 5;
    localparam logic [31:0] PSW_RESET = 32'h0000_0020;
    // -------------------------------------------------------------
    // handler addresses
    // -------------------------------------------------------------
    localparam logic [31:0] TRAP_VEC_LO_ADDR = 32'h0000_0040;
    localparam logic [31:0] TRAP_VEC_HI_ADDR = 32'h0000_0050;
    localparam logic [31:0] DEBUG_HANDLER_ADDR = 32'h0000_0060;
    localparam logic [4:0] TRAP_VEC_SPLIT = 5'h10;
    localparam logic [15:0] TRAP_CODE_BASE = 16'h0040;
    // -------------------------------------------------------------
    // illegal opcode decode fields
    // -------------------------------------------------------------
    localparam int OPC_LSB = 5;
    localparam int OPC_MSB = 10;
    localparam logic [5:0] OPC_ILLEGAL = 6'h3f;
    localparam int SUB_LSB = 23;
    localparam int SUB_MSB = 26;
    localparam logic [3:0] SUB_ILLEGAL_MIN = 4'h7;
    localparam int SUB_BIT16 = 16;
    // -------------------------------------------------------------
    // maskable requests
    // -------------------------------------------------------------
    localparam int NUM_REQ = 8;
    localparam int REQ_IDX_W = 3;
    localparam int LVL_W = 3;
    localparam int NUM_LVL = 8;
    localparam logic [2:0] LVL_RESET = 3'h7;
    localparam logic [NUM_LVL-1:0] IN_SERVICE_PRIORITY_RESET = 8'h00;
    // -------------------------------------------------------------
    // apb register offsets (byte addresses)
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_PSW = 8'h00;
    localparam logic [7:0] OFS_EXC_PC = 8'h04;
    localparam logic [7:0] OFS_EXC_STATUS = 8'h08;
    localparam logic [7:0] OFS_CAUSE = 8'h0c;
    localparam logic [7:0] OFS_DBG_PC = 8'h10;
    localparam logic [7:0] OFS_DBG_STATUS = 8'h14;
    localparam logic [7:0] OFS_IN_SERVICE_PRIORITY = 8'h18;
    localparam logic [7:0] OFS_INT_CTRL = 8'h20;
    // int control word layout: bits 2:0 level, bit 6 mask, bit 7 pending
    localparam int IC_MK_BIT = 6;
    localparam int IC_IF_BIT = 7;
    localparam logic [7:0] IC_RESET = 8'h47;
endpackage

/* File: int_ctrl_mem.sv */
// small memory holding the per-request interrupt control words
`timescale 1ns/10ps
module int_ctrl_mem (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_idx,
    input wire logic [7:0] i_wr_data,
    input wire logic [2:0] i_rd_idx,
    output logic [7:0] o_rd_data,
    output logic [63:0] o_all
);
    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    logic [7:0] ctrl_reg [8]; // one control word per request
    logic [7:0] rd_reg; // registered read data

    // reset leaves every request masked at the lowest level
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            for (int k = 0; k < 8; k++) begin
                ctrl_reg[k] <= exc_nest_pkg::IC_RESET;
            end
            rd_reg <= 8'h00;
        end else begin
            if (i_wr_en) begin
                ctrl_reg[i_wr_idx] <= i_wr_data;
            end
            rd_reg <= ctrl_reg[i_rd_idx];
        end
    end

    assign o_rd_data = rd_reg;
    // flat view for the arbiter
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            o_all[k*8 +: 8] = ctrl_reg[k];
        end
    end
endmodule // int_ctrl_mem

/* File: cpu_exception_nesting_unit.sv */
// exception, debug trap and nested maskable interrupt control
// How it works
// - trap instruction raises software exception unless a debug entry comes in the same cycle
// - exception saves return pc and status
// - exception code goes to low cause half
// - exception sets in-progress and disable flags
// - trap vector picks handler 40h or 50h
// - return with in-progress restores exception save
// - in-progress flag is status bit six
// - decode illegal opcode pattern raises fault
// - bad opcode saves debug regs, jumps 60h
// - bad opcode sets nmi, in-progress, disable flags
// - debug return restores debug save registers
// - debug saves readable only inside debug window
// - break instruction always accepted, like bad opcode
// - higher level preempts, lower level stays pending
// - nesting only while disable flag clear
// - three-bit level, zero highest
// - reset masks requests, level seven
// - pending request waits for return instruction
// - nmi service holds all maskable requests
// - response may stall on bus or peripheral access
// - disable flag is status bit five
// - return clears top in-service bit unless exception or nmi service
`timescale 1ns/10ps
module cpu_exception_nesting_unit (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    // pipeline event strobes (same clock)
    input wire logic i_trap_op,
    input wire logic [4:0] i_trap_vec,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr_word,
    input wire logic i_debugger_break_op,
    input wire logic i_return_from_int_op,
    input wire logic i_debug_return_op,
    input wire logic i_nmi_take,
    input wire logic i_stall_ack,
    input wire logic [31:0] i_return_pc,
    input wire logic [7:0] i_req_raise,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // pipeline redirect
    output logic o_redirect,
    output logic [31:0] o_redirect_pc,
    output logic [31:0] o_program_status_word,
    output logic o_int_ack,
    output logic [2:0] o_int_ack_idx
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [31:0] psw_reg, psw_next; // program status word
    logic [31:0] exc_return_pc_reg; // exception save pc
    logic [31:0] exc_return_status_reg; // exception save status
    logic [31:0] exception_cause_reg; // cause, code in low half
    logic [31:0] debug_return_pc_reg; // debug save pc
    logic [31:0] debug_return_status_reg; // debug save status
    logic debug_window_reg; // debug saves reachable
    logic nmi_active_reg; // inside nmi service
    logic [7:0] in_service_priority_reg; // one bit per level
    logic [7:0] req_pend_reg; // pending flags
    logic redirect_reg;
    logic [31:0] redirect_pc_reg;
    logic ack_reg;
    logic [2:0] ack_idx_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    typedef enum logic [1:0] {APB_IDLE, APB_DONE} apb_state_e;
    apb_state_e apb_state_reg;

    // -------------------------------------------------------------
    // helper functions
    // -------------------------------------------------------------
    // lowest set bit index, i.e. highest priority level
    function automatic logic [2:0] lowest_bit(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h7;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                r = k[2:0];
            end
        end
        return r;
    endfunction

    // -------------------------------------------------------------
    // control memory
    // -------------------------------------------------------------
    logic [63:0] ic_all;
    logic [7:0] ic_rd;
    wire ic_sel = i_paddr >= exc_nest_pkg::OFS_INT_CTRL
        && i_paddr < exc_nest_pkg::OFS_INT_CTRL + 8'h20;
    wire [2:0] ic_idx = i_paddr[4:2];
    wire apb_go = i_psel && i_penable && apb_state_reg == APB_IDLE;
    wire ic_wr = apb_go && i_pwrite && ic_sel;

    int_ctrl_mem u_ic (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_wr_en(ic_wr),
        .i_wr_idx(ic_idx),
        .i_wr_data(i_pwdata[7:0]),
        .i_rd_idx(ic_idx),
        .o_rd_data(ic_rd),
        .o_all(ic_all)
    );

    // -------------------------------------------------------------
    // instruction decode
    // -------------------------------------------------------------
    wire bad_opcode_fault = i_instr_valid
        && i_instr_word[exc_nest_pkg::OPC_MSB:exc_nest_pkg::OPC_LSB] == exc_nest_pkg::OPC_ILLEGAL
        && i_instr_word[exc_nest_pkg::SUB_MSB:exc_nest_pkg::SUB_LSB]
            >= exc_nest_pkg::SUB_ILLEGAL_MIN
        && !i_instr_word[exc_nest_pkg::SUB_BIT16];
    wire debug_entry = bad_opcode_fault || i_debugger_break_op;
    wire id_flag = psw_reg[exc_nest_pkg::PSW_ID_BIT];
    wire ep_flag = psw_reg[exc_nest_pkg::PSW_EP_BIT];
    wire [31:0] trap_target = (i_trap_vec >= exc_nest_pkg::TRAP_VEC_SPLIT)
        ? exc_nest_pkg::TRAP_VEC_HI_ADDR : exc_nest_pkg::TRAP_VEC_LO_ADDR;
    wire return_from_int_op_exc = i_return_from_int_op && ep_flag;

    // -------------------------------------------------------------
    // maskable arbitration
    // -------------------------------------------------------------
    logic [2:0] best_idx;
    logic [2:0] best_lvl;
    logic best_valid;
    always_comb begin
        best_idx = 3'h0;
        best_lvl = exc_nest_pkg::LVL_RESET;
        best_valid = 1'b0;
        // fixed scan order: lower index wins a tie
        for (int k = 0; k < 8; k++) begin
            if (req_pend_reg[k] && !ic_all[k*8 + exc_nest_pkg::IC_MK_BIT]
                && (!best_valid || ic_all[k*8 +: 3] < best_lvl)) begin
                best_idx = k[2:0];
                best_lvl = ic_all[k*8 +: 3];
                best_valid = 1'b1;
            end
        end
    end
    wire [2:0] top_isr = lowest_bit(in_service_priority_reg);
    wire isr_busy = |in_service_priority_reg;
    // a request is taken only if it beats the running level
    wire preempt_ok = !isr_busy || best_lvl < top_isr;
    wire int_take = best_valid && preempt_ok && !id_flag
        && !nmi_active_reg && !i_nmi_take
        && !i_stall_ack
        && !i_trap_op && !debug_entry && !i_return_from_int_op && !i_debug_return_op;

    // -------------------------------------------------------------
    // status word next value
    // -------------------------------------------------------------
    logic [31:0] psw_wr_data;
    wire psw_wr = apb_go && i_pwrite && i_paddr == exc_nest_pkg::OFS_PSW;
    always_comb begin
        psw_wr_data = i_pwdata;
        psw_next = psw_reg;
        if (debug_entry) begin
            psw_next[exc_nest_pkg::PSW_NP_BIT] = 1'b1;
            psw_next[exc_nest_pkg::PSW_EP_BIT] = 1'b1;
            psw_next[exc_nest_pkg::PSW_ID_BIT] = 1'b1;
        end else if (i_trap_op) begin
            psw_next[exc_nest_pkg::PSW_EP_BIT] = 1'b1;
            psw_next[exc_nest_pkg::PSW_ID_BIT] = 1'b1;
        end else if (i_debug_return_op) begin
            psw_next = debug_return_status_reg;
        end else if (return_from_int_op_exc) begin
            psw_next = exc_return_status_reg;
        end else if (int_take || i_nmi_take) begin
            psw_next[exc_nest_pkg::PSW_ID_BIT] = 1'b1;
        end else if (psw_wr) begin
            psw_next = psw_wr_data;
        end
    end

    // -------------------------------------------------------------
    // event handling: save registers, redirects
    // -------------------------------------------------------------
    // save registers and redirect, one event per cycle by priority
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            psw_reg <= exc_nest_pkg::PSW_RESET;
            exc_return_pc_reg <= 32'h0000_0000;
            exc_return_status_reg <= 32'h0000_0000;
            exception_cause_reg <= 32'h0000_0000;
            debug_return_pc_reg <= 32'h0000_0000;
            debug_return_status_reg <= 32'h0000_0000;
            debug_window_reg <= 1'b0;
            redirect_reg <= 1'b0;
            redirect_pc_reg <= 32'h0000_0000;
        end else begin
            psw_reg <= psw_next;
            redirect_reg <= 1'b0;
            if (debug_entry) begin
                // debug entry is always accepted
                debug_return_pc_reg <= i_return_pc;
                debug_return_status_reg <= psw_reg;
                debug_window_reg <= 1'b1;
                redirect_reg <= 1'b1;
                redirect_pc_reg <= exc_nest_pkg::DEBUG_HANDLER_ADDR;
            end else if (i_trap_op) begin
                // taken regardless of disable flag and level
                exc_return_pc_reg <= i_return_pc;
                exc_return_status_reg <= psw_reg;
                exception_cause_reg[15:0] <= exc_nest_pkg::TRAP_CODE_BASE
                    | {11'h000, i_trap_vec};
                redirect_reg <= 1'b1;
                redirect_pc_reg <= trap_target;
            end else if (i_debug_return_op) begin
                debug_window_reg <= 1'b0;
                redirect_reg <= 1'b1;
                redirect_pc_reg <= debug_return_pc_reg;
            end else if (return_from_int_op_exc) begin
                redirect_reg <= 1'b1;
                redirect_pc_reg <= exc_return_pc_reg;
            end else if (int_take) begin
                exc_return_pc_reg <= i_return_pc;
                exc_return_status_reg <= psw_reg;
                exception_cause_reg[15:0] <= {13'h0000, best_idx};
            end else if (apb_go && i_pwrite) begin
                // software may save and restore nested context
                if (i_paddr == exc_nest_pkg::OFS_EXC_PC) begin
                    exc_return_pc_reg <= i_pwdata;
                end
                if (i_paddr == exc_nest_pkg::OFS_EXC_STATUS) begin
                    exc_return_status_reg <= i_pwdata;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // nesting state: pending flags, in-service levels, nmi
    // -------------------------------------------------------------
    wire [7:0] take_mask = int_take ? (8'h01 << best_idx) : 8'h00;
    wire [7:0] lvl_mask = int_take ? (8'h01 << best_lvl) : 8'h00;
    wire return_from_int_op_plain = i_return_from_int_op && !ep_flag && !nmi_active_reg;
    wire [7:0] clr_isr = return_from_int_op_plain ? (8'h01 << top_isr) : 8'h00;
    // pending, in-service and nmi bookkeeping, acknowledge pulse
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            req_pend_reg <= 8'h00;
            in_service_priority_reg <= exc_nest_pkg::IN_SERVICE_PRIORITY_RESET;
            nmi_active_reg <= 1'b0;
            ack_reg <= 1'b0;
            ack_idx_reg <= 3'h0;
        end else begin
            // a new raise beats the acknowledge clear
            req_pend_reg <= (req_pend_reg & ~take_mask) | i_req_raise;
            in_service_priority_reg <= (in_service_priority_reg & ~clr_isr) | lvl_mask;
            if (i_nmi_take) begin
                nmi_active_reg <= 1'b1;
            end else if (i_return_from_int_op && nmi_active_reg) begin
                nmi_active_reg <= 1'b0;
            end
            ack_reg <= int_take;
            ack_idx_reg <= best_idx;
        end
    end

    // -------------------------------------------------------------
    // apb read decode, one wait state
    // -------------------------------------------------------------
    logic [31:0] rd_mux;
    logic rd_err;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (ic_sel) begin
            rd_mux = {24'h000000, ic_all[ic_idx*8 +: 8] | (req_pend_reg[ic_idx]
                ? 8'h80 : 8'h00)};
        end else begin
            case (i_paddr)
                exc_nest_pkg::OFS_PSW: rd_mux = psw_reg;
                exc_nest_pkg::OFS_EXC_PC: rd_mux = exc_return_pc_reg;
                exc_nest_pkg::OFS_EXC_STATUS: rd_mux = exc_return_status_reg;
                exc_nest_pkg::OFS_CAUSE: rd_mux = exception_cause_reg;
                exc_nest_pkg::OFS_DBG_PC: begin
                    rd_mux = debug_window_reg ? debug_return_pc_reg : 32'h0;
                    rd_err = !debug_window_reg;
                end
                exc_nest_pkg::OFS_DBG_STATUS: begin
                    rd_mux = debug_window_reg ? debug_return_status_reg : 32'h0;
                    rd_err = !debug_window_reg;
                end
                exc_nest_pkg::OFS_IN_SERVICE_PRIORITY: rd_mux = {24'h000000, in_service_priority_reg};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // answer one cycle after the access phase is seen, then rest a cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            apb_state_reg <= APB_IDLE;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            case (apb_state_reg)
                APB_IDLE: begin
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                    if (i_psel && i_penable) begin
                        apb_state_reg <= APB_DONE;
                        pready_reg <= 1'b1;
                        prdata_reg <= i_pwrite ? 32'h0 : rd_mux;
                        pslverr_reg <= rd_err;
                    end
                end
                APB_DONE: begin
                    apb_state_reg <= APB_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
                default: apb_state_reg <= APB_IDLE;
            endcase
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_redirect = redirect_reg;
    assign o_redirect_pc = redirect_pc_reg;
    assign o_program_status_word = psw_reg;
    assign o_int_ack = ack_reg;
    assign o_int_ack_idx = ack_idx_reg;
endmodule // cpu_exception_nesting_unit

/* File: cpu_exception_nesting_unit_props.sv */
// assertion checker for the exception nesting unit ports
`timescale 1ns/10ps
module exc_nest_props (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_trap_op,
    input wire logic [4:0] i_trap_vec,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr_word,
    input wire logic i_debugger_break_op,
    input wire logic i_nmi_take,
    input wire logic i_stall_ack,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_redirect,
    input wire logic [31:0] o_redirect_pc,
    input wire logic [31:0] o_program_status_word,
    input wire logic o_int_ack
);
    // --------------------------------
    // decode of the event causes
    // --------------------------------
    wire logic bad_op = i_instr_valid && i_instr_word[10:5] == 6'h3f
        && i_instr_word[26:23] >= 4'h7 && !i_instr_word[16];
    wire logic dbg_in = bad_op || i_debugger_break_op;  // debug entry outranks trap
    wire logic trap_in = i_trap_op && !dbg_in;
    wire logic [31:0] program_status_word = o_program_status_word;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    trap_redirect_a: assert property (trap_in |=> o_redirect
        && o_redirect_pc == ($past(i_trap_vec[4]) ? 32'h0000_0050 : 32'h0000_0040))
        else $error("trap handler address wrong");
    trap_flags_a: assert property (trap_in |=> program_status_word[6:5] == 2'h3)
        else $error("trap flags not set");
    dbg_entry_a: assert property (dbg_in |=> o_redirect
        && o_redirect_pc == 32'h0000_0060 && program_status_word[7:5] == 3'h7)
        else $error("debug entry wrong");
    reset_psw_a: assert property ($rose(i_resetn) |-> program_status_word == 32'h0000_0020)
        else $error("status word reset value wrong");
    ack_cause_a: assert property (o_int_ack |-> !$past(program_status_word[5]) && !$past(i_stall_ack))
        else $error("request taken while disabled or stalled");
    ack_disable_a: assert property (o_int_ack |-> program_status_word[5] ##1 !o_int_ack)
        else $error("acceptance did not set disable flag");
    nmi_hold_a: assert property (i_nmi_take |=> !o_int_ack [*2])
        else $error("request taken in nmi service");
    apb_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("bus answer late");
    trap_c: cover property (trap_in ##1 o_redirect);
    dbg_c: cover property (bad_op ##1 o_redirect);
    ack_c: cover property (o_int_ack);
endmodule // exc_nest_props

bind cpu_exception_nesting_unit exc_nest_props exc_nest_props_inst (.i_sys_clk, .i_resetn,
    .i_trap_op, .i_trap_vec, .i_instr_valid, .i_instr_word, .i_debugger_break_op,
    .i_nmi_take, .i_stall_ack, .i_psel, .i_penable, .o_pready, .o_redirect,
    .o_redirect_pc, .o_program_status_word, .o_int_ack);

/* File: req_src_model.sv */
// request source and bus stall model for the pipeline side
`timescale 1ns/10ps
module req_src_model (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_fire,
    input wire logic [3:0] i_busy_len,
    input wire logic i_busy_go,
    output logic [7:0] o_raise,
    output logic o_stall
);
    logic [3:0] busy_reg;  // cycles of stall still to run
    // one raise pulse per fired line, stall counts down to zero
    always_ff @(posedge i_sys_clk) begin
        o_raise <= i_resetn ? i_fire : 8'h00;
        busy_reg <= !i_resetn ? 4'h0 : i_busy_go ? i_busy_len
            : busy_reg - {3'h0, busy_reg != 4'h0};
    end
    assign o_stall = busy_reg != 4'h0;  // slow peripheral access
endmodule // req_src_model

/* File: cpu_exception_nesting_unit_tb.sv */
// self-checking bench for the exception nesting unit
`timescale 1ns/10ps
module cpu_exception_nesting_unit_tb;
    logic i_sys_clk = 0, i_resetn = 0, nmi = 0, psel = 0, pen = 0, pwr = 0, bgo = 0;
    logic [4:0] ev = 0, vec = 0;  // strobes: trap, break, return, debug return, valid
    logic [31:0] word = 0, rpc = 0, pwd = 0, prdata, rpc_out, psw_out, program_status_word, sv, r, w;
    logic [7:0] paddr = 0, fire = 0, raise;
    logic stall, pready, pslverr, redir, ack;
    logic [2:0] ack_idx;
    logic [32:0] exp_rd[$], exp_pc[$], exp_ack[$];
    logic [4:0] vt [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
    int errors = 0, num_checks = 0, cyc = 0;
    req_src_model req_src_model_inst (.i_sys_clk, .i_resetn, .i_fire(fire),
        .i_busy_len(4'h6), .i_busy_go(bgo), .o_raise(raise), .o_stall(stall));
    cpu_exception_nesting_unit cpu_exception_nesting_unit_inst (.i_sys_clk, .i_resetn,
        .i_trap_op(ev[0]), .i_trap_vec(vec), .i_instr_valid(ev[4]), .i_instr_word(word),
        .i_debugger_break_op(ev[1]), .i_return_from_int_op(ev[2]),
        .i_debug_return_op(ev[3]), .i_nmi_take(nmi), .i_stall_ack(stall),
        .i_return_pc(rpc), .i_req_raise(raise), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_redirect(redir),
        .o_redirect_pc(rpc_out), .o_program_status_word(psw_out), .o_int_ack(ack),
        .o_int_ack_idx(ack_idx));
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    // --------------------------------
    // checking and closing
    // --------------------------------
    task automatic tally_and_finish;
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // oldest note is compared whenever a result shows
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc > 6000) begin
            errors++;
            tally_and_finish;
        end
        if (pready && !pwr) chk(exp_rd.size() ? exp_rd.pop_front() : 33'hx, {pslverr, prdata});
        if (redir) chk(exp_pc.size() ? exp_pc.pop_front() : 33'hx, {1'b0, rpc_out});
        if (ack) chk(exp_ack.size() ? exp_ack.pop_front() : 33'hx, {30'h0, ack_idx});
    end
    // one bus transfer, held until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwd <= d;
        if (!wr) exp_rd.push_back(e);
        @(posedge i_sys_clk);
        pen <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    // one-cycle pipeline event carrying pc and vector from r
    task automatic ev_go(input logic [4:0] k, input logic [31:0] iw);
        ev <= k;
        word <= iw;
        rpc <= r;
        vec <= r[4:0];
        @(posedge i_sys_clk);
        ev <= 5'h00;
        repeat (3) @(posedge i_sys_clk);
    endtask
    initial begin
        r = $urandom(50799);
        repeat (8) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        @(posedge i_sys_clk);
        apb(0, 8'h00, 0, 33'h20);
        apb(0, 8'h20, 0, 33'h47);
        apb(0, 8'hfc, 0, 33'h1_0000_0000);
        apb(0, 8'h10, 0, 33'h1_0000_0000);
        for (int i = 0; i < 5; i++) begin
            program_status_word = {26'h0, i[0], 5'h0};
            apb(1, 8'h00, program_status_word, 0);
            sv = program_status_word;
            r = $urandom();
            if (i < 4) r[4:0] = vt[i];
            exp_pc.push_back(r[4] ? 33'h50 : 33'h40);
            ev_go(5'h01, 0);
            program_status_word = program_status_word | 32'h60;
            apb(0, 8'h00, 0, {1'b0, program_status_word});
            apb(0, 8'h0c, 0, {17'h0, 11'h002, r[4:0]});
            apb(0, 8'h04, 0, {1'b0, r});
            apb(0, 8'h08, 0, {1'b0, sv});
            exp_pc.push_back({1'b0, r});
            ev_go(5'h04, 0);
            apb(0, 8'h00, 0, {1'b0, sv});
        end
        for (int i = 0; i < 2; i++) begin
            program_status_word = sv;
            r = $urandom();
            w = $urandom();
            w[10:5] = 6'h3f;
            w[26:23] = 4'h7 + 4'($urandom_range(8));
            w[16] = 1'b0;
            exp_pc.push_back(33'h60);
            ev_go(i ? 5'h02 : 5'h10, w);
            apb(0, 8'h00, 0, {1'b0, program_status_word | 32'he0});
            apb(0, 8'h10, 0, {1'b0, r});
            apb(0, 8'h14, 0, {1'b0, sv});
            exp_pc.push_back({1'b0, r});
            ev_go(5'h08, 0);
            apb(0, 8'h00, 0, {1'b0, sv});
        end
        w[16] = 1'b1;
        ev_go(5'h10, w);
        w[26:23] = 4'h6;
        w[16] = 1'b0;
        ev_go(5'h10, w);
        apb(0, 8'h14, 0, 33'h1_0000_0000);
        apb(1, 8'h24, 32'h3, 0);
        apb(1, 8'h28, 32'h3, 0);
        apb(1, 8'h20, 32'h5, 0);
        apb(0, 8'h24, 0, 33'h03);
        apb(1, 8'h00, 32'h20, 0);
        fire <= 8'h27;
        @(posedge i_sys_clk);
        fire <= 8'h00;
        exp_ack.push_back(33'h1);
        apb(1, 8'h00, 0, 0);
        apb(0, 8'h18, 0, 33'h08);
        apb(1, 8'h00, 0, 0);
        apb(1, 8'h2c, 32'h1, 0);
        bgo <= 1'b1;
        fire <= 8'h08;
        @(posedge i_sys_clk);
        bgo <= 1'b0;
        fire <= 8'h00;
        exp_ack.push_back(33'h3);
        repeat (12) @(posedge i_sys_clk);
        apb(0, 8'h18, 0, 33'h0a);
        nmi <= 1'b1;
        @(posedge i_sys_clk);
        nmi <= 1'b0;
        apb(1, 8'h30, 32'h0, 0);
        apb(1, 8'h00, 0, 0);
        fire <= 8'h10;
        @(posedge i_sys_clk);
        fire <= 8'h00;
        repeat (10) @(posedge i_sys_clk);
        exp_ack.push_back(33'h4);
        ev_go(5'h04, 0);
        ev_go(5'h04, 0);
        apb(0, 8'h18, 0, 33'h0a);
        if (exp_rd.size() + exp_pc.size() + exp_ack.size() != 0) errors++;
        tally_and_finish;
    end
endmodule // cpu_exception_nesting_unit_tb
